// file: verilog/expander_pkg.sv
// Purpose: shared constants and types of the 16-bit I2C port expander core
// Assumes: one 50 MHz clock, bus pins sampled synchronously
// Notes:   command codes select one of eight byte registers
package expander_pkg;
   localparam int          CLOCK_HZ        = 50_000_000;
   localparam int          PORT_WIDTH      = 8;
   localparam logic [6:0]  TARGET_BASE     = 7'h20;
   localparam logic [2:0]  CMD_INPUT0      = 3'h0;
   localparam logic [2:0]  CMD_INPUT1      = 3'h1;
   localparam logic [2:0]  CMD_OUTPUT0     = 3'h2;
   localparam logic [2:0]  CMD_OUTPUT1     = 3'h3;
   localparam logic [2:0]  CMD_POLARITY0   = 3'h4;
   localparam logic [2:0]  CMD_POLARITY1   = 3'h5;
   localparam logic [2:0]  CMD_CONFIG0     = 3'h6;
   localparam logic [2:0]  CMD_CONFIG1     = 3'h7;
   localparam logic [7:0]  OUTPUT_RESET    = 8'hFF;
   localparam logic [7:0]  POLARITY_RESET  = 8'h00;
   localparam logic [7:0]  CONFIG_RESET    = 8'hFF;
   localparam logic [2:0]  CMD_RESET       = 3'h0;
   localparam int          BIT_COUNT_BYTE  = 8;

   typedef enum logic [2:0] {
      BUS_IDLE,
      BUS_ADDR,
      BUS_ADDR_ACK,
      BUS_WRITE,
      BUS_WRITE_ACK,
      BUS_READ,
      BUS_READ_ACK
   } bus_state_e;
endpackage : expander_pkg

// file: verilog/port_sync_if.sv
// Purpose: carries raw and synchronised pin levels between modules
// Assumes: single clock domain
// Notes:   sync end drives pins_sync, core reads it
`timescale 1ns/1ns
interface port_sync_if;
   logic [15:0] pins_raw;
   logic [15:0] pins_sync;
   modport sync (input pins_raw, output pins_sync);
   modport core (output pins_raw, input pins_sync);
endinterface : port_sync_if

// file: verilog/pin_synchroniser.sv
// Purpose: two-stage synchroniser for the sixteen port pin inputs
// Assumes: pins asynchronous to clock in a real system
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ns
module pin_synchroniser (
   // Clock and reset
   input  wire logic  clock,
   input  wire logic  rst_n,
   input  wire logic  clock_enable,
   // Pin levels
   port_sync_if.sync  pins
);
   logic [15:0] stage1;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stage1         <= 16'h0000;
         pins.pins_sync <= 16'h0000;
      end else if (clock_enable) begin
         stage1         <= pins.pins_raw;
         pins.pins_sync <= stage1;
      end
   end
endmodule : pin_synchroniser

// file: verilog/io_expander_core.sv
// Purpose: 16-bit I2C target I/O expander core with change interrupt
// Assumes: scl/sda sampled synchronously at 50 MHz; rst_n covers pin and power-on reset
// Notes:   open-drain pins are split into level in and drive-low enable out
// Behaviour
// - Interrupt asserts when any input-mode pin differs from its latched input value.
// - Interrupt is active low open drain; only a pull-low enable is driven.
// - Both rising and falling input transitions cause interrupts.
// - Interrupt clears when pin returns, or when the port's input is read.
// - Read clear happens at the read ACK/NACK bit after its SCL rising edge.
// - A change during the clearing ACK pulse may be lost or very short.
// - After clearing, each later input change raises the interrupt again.
// - Transfers to other targets leave interrupt logic untouched.
// - Output-mode pins never generate interrupts.
// - Switching output to input may raise an interrupt on mismatch.
// - Input-mode pins have both drivers off.
// - Output-mode pins enable high or low driver from output register bit.
// - Reset low holds all registers and the bus machine at defaults.
// - Pin reset and power-on reset initialise identically.
// - After any reset every pin is an input.
// - Eight byte registers: input, output, polarity, configuration pairs.
// - Polarity bit inverts the reported input value.
// - Configuration writes set each pin's direction.
// - All eight registers are readable.
// - Address strap selects one of two target addresses.
// - Target address 20h with strap low, 21h with strap high; LSB is read.
// - First written byte is the command selecting register 0 through 7.
// - Selected register stays selected until a new command byte.
// - Writes to input registers are ignored.
`timescale 1ns/1ns
module io_expander_core
   import expander_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        clock_enable,
   // Bus pins
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_oe,
   input  wire logic        addr_strap,
   // Port pins
   input  wire logic [7:0]  port0_pins_in,
   input  wire logic [7:0]  port1_pins_in,
   output logic [7:0]       port0_pins_out,
   output logic [7:0]       port1_pins_out,
   output logic [7:0]       port0_pins_oe,
   output logic [7:0]       port1_pins_oe,
   // Interrupt
   output logic             change_irq_oe
);
   import expander_pkg::*;

   port_sync_if sync_bus ();
   assign sync_bus.pins_raw = {port1_pins_in, port0_pins_in};

   pin_synchroniser u_sync (
      .clock        (clock),
      .rst_n        (rst_n),
      .clock_enable (clock_enable),
      .pins         (sync_bus.sync)
   );

   logic [15:0] pins_now;
   assign pins_now = sync_bus.pins_sync;

   // Registers
   logic [15:0] input_latch;
   logic [15:0] output_reg;
   logic [15:0] polarity_reg;
   logic [15:0] config_reg;
   logic [7:0]  view_now;
   logic [15:0] input_view;
   // Reads report the live pin levels; the latch is only the interrupt reference
   assign input_view = pins_now ^ polarity_reg;

   // Bus line history for start/stop and edges
   logic scl_d;
   logic sda_d;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   assign scl_rise   = scl_in && !scl_d;
   assign scl_fall   = !scl_in && scl_d;
   assign start_seen = scl_in && scl_d && sda_d && !sda_in;
   assign stop_seen  = scl_in && scl_d && !sda_d && sda_in;

   bus_state_e  state;
   logic [7:0]  shift;
   logic [3:0]  bit_count;
   logic        read_mode;
   logic        first_byte;
   logic [2:0]  rd_ptr;
   logic        write_strobe;
   logic        read_clear;
   logic [2:0]  read_reg_sel;

   function automatic logic [7:0] reg_view(input logic [2:0] sel, input logic [15:0] inv,
                                           input logic [15:0] outr, input logic [15:0] pol,
                                           input logic [15:0] cfg);
      logic [7:0] value;
      value = 8'h00;
      unique case (sel)
         CMD_INPUT0:    value = inv[7:0];
         CMD_INPUT1:    value = inv[15:8];
         CMD_OUTPUT0:   value = outr[7:0];
         CMD_OUTPUT1:   value = outr[15:8];
         CMD_POLARITY0: value = pol[7:0];
         CMD_POLARITY1: value = pol[15:8];
         CMD_CONFIG0:   value = cfg[7:0];
         CMD_CONFIG1:   value = cfg[15:8];
      endcase
      return value;
   endfunction : reg_view

   function automatic logic addr_match(input logic [6:0] addr, input logic strap);
      return addr == {TARGET_BASE[6:1], strap};
   endfunction : addr_match

   assign view_now = reg_view(rd_ptr, input_view, output_reg, polarity_reg, config_reg);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else if (clock_enable) begin
         scl_d <= scl_in;
         sda_d <= sda_in;
      end
   end

   // Bus protocol machine; reset puts it in idle, same for any reset source
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state        <= BUS_IDLE;
         shift        <= 8'h00;
         bit_count    <= 4'h0;
         read_mode    <= 1'b0;
         first_byte   <= 1'b0;
         rd_ptr       <= CMD_RESET;
         sda_oe       <= 1'b0;
         write_strobe <= 1'b0;
         read_clear   <= 1'b0;
         read_reg_sel <= CMD_RESET;
      end else if (clock_enable) begin
         write_strobe <= 1'b0;
         read_clear   <= 1'b0;
         if (stop_seen) begin
            state  <= BUS_IDLE;
            sda_oe <= 1'b0;
         end else if (start_seen) begin
            state     <= BUS_ADDR;
            bit_count <= 4'h0;
            sda_oe    <= 1'b0;
         end else begin
            unique case (state)
               BUS_IDLE: sda_oe <= 1'b0;
               BUS_ADDR: begin
                  if (scl_rise) begin
                     shift     <= {shift[6:0], sda_in};
                     bit_count <= bit_count + 4'h1;
                  end else if (scl_fall && bit_count == 4'(BIT_COUNT_BYTE)) begin
                     // Other targets: stay idle, interrupt logic sees nothing
                     if (addr_match(shift[7:1], addr_strap)) begin
                        state      <= BUS_ADDR_ACK;
                        sda_oe     <= 1'b1;
                        read_mode  <= shift[0];
                        first_byte <= 1'b1;
                     end else begin
                        state <= BUS_IDLE;
                     end
                  end
               end
               BUS_ADDR_ACK: begin
                  if (scl_fall) begin
                     bit_count <= 4'h0;
                     if (read_mode) begin
                        state  <= BUS_READ;
                        shift  <= view_now;
                        read_reg_sel <= rd_ptr;
                        sda_oe <= !view_now[7];
                     end else begin
                        state  <= BUS_WRITE;
                        sda_oe <= 1'b0;
                     end
                  end
               end
               BUS_WRITE: begin
                  if (scl_rise) begin
                     shift     <= {shift[6:0], sda_in};
                     bit_count <= bit_count + 4'h1;
                  end else if (scl_fall && bit_count == 4'(BIT_COUNT_BYTE)) begin
                     state  <= BUS_WRITE_ACK;
                     sda_oe <= 1'b1;
                     if (first_byte) begin
                        rd_ptr     <= shift[2:0];
                        first_byte <= 1'b0;
                     end else begin
                        write_strobe <= 1'b1;
                     end
                  end
               end
               BUS_WRITE_ACK: begin
                  if (scl_fall) begin
                     state     <= BUS_WRITE;
                     sda_oe    <= 1'b0;
                     bit_count <= 4'h0;
                     // Pointer is kept across data bytes; no auto-advance
                     if (write_strobe == 1'b0 && !first_byte) begin
                        rd_ptr <= rd_ptr;
                     end
                  end
               end
               BUS_READ: begin
                  if (scl_fall) begin
                     if (bit_count == 4'(BIT_COUNT_BYTE - 1)) begin
                        state  <= BUS_READ_ACK;
                        sda_oe <= 1'b0;
                     end else begin
                        shift     <= {shift[6:0], 1'b0};
                        bit_count <= bit_count + 4'h1;
                        sda_oe    <= !shift[6];
                     end
                  end
               end
               BUS_READ_ACK: begin
                  if (scl_rise) begin
                     read_clear <= 1'b1;
                     if (sda_in) begin
                        state <= BUS_IDLE;
                     end
                  end else if (scl_fall) begin
                     state        <= BUS_READ;
                     bit_count    <= 4'h0;
                     shift        <= view_now;
                     read_reg_sel <= rd_ptr;
                     sda_oe       <= !view_now[7];
                  end
               end
            endcase
         end
      end
   end

   // Register writes; command already points at target
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         output_reg   <= {OUTPUT_RESET, OUTPUT_RESET};
         polarity_reg <= {POLARITY_RESET, POLARITY_RESET};
         config_reg   <= {CONFIG_RESET, CONFIG_RESET};
      end else if (clock_enable && write_strobe) begin
         unique case (rd_ptr)
            CMD_OUTPUT0:   output_reg[7:0]    <= shift;
            CMD_OUTPUT1:   output_reg[15:8]   <= shift;
            CMD_POLARITY0: polarity_reg[7:0]  <= shift;
            CMD_POLARITY1: polarity_reg[15:8] <= shift;
            CMD_CONFIG0:   config_reg[7:0]    <= shift;
            CMD_CONFIG1:   config_reg[15:8]   <= shift;
            default:       ;
         endcase
      end
   end

   logic       sync_primed;
   logic [1:0] prime_count;

   // Input latch: captured when a port's input is read, at the ACK bit.
   // Latch mismatch is the interrupt source, so a pin returning to its old
   // level clears it with no action from software.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         input_latch <= 16'h0000;
      end else if (clock_enable) begin
         if (state == BUS_IDLE && !sync_primed) begin
            input_latch <= pins_now;
         end else if (read_clear && read_reg_sel == CMD_INPUT0) begin
            input_latch[7:0] <= pins_now[7:0];
         end else if (read_clear && read_reg_sel == CMD_INPUT1) begin
            input_latch[15:8] <= pins_now[15:8];
         end
      end
   end

   // First capture after reset waits out the synchroniser fill
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prime_count <= 2'h0;
         sync_primed <= 1'b0;
      end else if (clock_enable && !sync_primed) begin
         prime_count <= prime_count + 2'h1;
         if (prime_count == 2'h2) begin
            sync_primed <= 1'b1;
         end
      end
   end

   // Interrupt: mismatch on any input-mode pin, either edge direction
   logic [15:0] mismatch;
   assign mismatch = (pins_now ^ input_latch) & config_reg;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         change_irq_oe <= 1'b0;
      end else if (clock_enable) begin
         change_irq_oe <= sync_primed && (|mismatch);
      end
   end

   // Pin drivers: output enable drives high or low from output register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         port0_pins_oe  <= 8'h00;
         port1_pins_oe  <= 8'h00;
         port0_pins_out <= OUTPUT_RESET;
         port1_pins_out <= OUTPUT_RESET;
      end else if (clock_enable) begin
         port0_pins_oe  <= ~config_reg[7:0];
         port1_pins_oe  <= ~config_reg[15:8];
         port0_pins_out <= output_reg[7:0];
         port1_pins_out <= output_reg[15:8];
      end
   end

   a_output_no_irq: assert property (@(posedge clock) disable iff (!rst_n)
      (clock_enable && ((pins_now ^ input_latch) & config_reg) == 16'h0000) |=> !change_irq_oe)
      else $error("output pins raised interrupt");
   a_mismatch_irq: assert property (@(posedge clock) disable iff (!rst_n)
      (clock_enable && sync_primed && |mismatch) |=> change_irq_oe)
      else $error("mismatch did not assert interrupt");
   a_input_hiz: assert property (@(posedge clock) disable iff (!rst_n)
      clock_enable |=> ((port0_pins_oe & $past(config_reg[7:0])) == 8'h00))
      else $error("input pin driven");
   a_input_write: assert property (@(posedge clock) disable iff (!rst_n)
      (write_strobe && clock_enable && rd_ptr[2:1] == 2'b00) |=> $stable(config_reg) && $stable(output_reg))
      else $error("input register write had effect");
   a_read_clear: assert property (@(posedge clock) disable iff (!rst_n)
      (read_clear && clock_enable && read_reg_sel == CMD_INPUT0 && sync_primed)
      |=> input_latch[7:0] == $past(pins_now[7:0]))
      else $error("read did not relatch input");
   a_clear_timing: assert property (@(posedge clock) disable iff (!rst_n)
      read_clear |-> $past(state) == BUS_READ_ACK)
      else $error("clear outside ack bit");
   a_foreign_addr: assert property (@(posedge clock) disable iff (!rst_n)
      (clock_enable && state == BUS_ADDR && scl_fall && bit_count == 4'h8 && !addr_match(shift[7:1], addr_strap)
       && !stop_seen && !start_seen) |=> state == BUS_IDLE && !read_clear)
      else $error("foreign address engaged");
   a_ack_drive: assert property (@(posedge clock) disable iff (!rst_n)
      (state == BUS_WRITE_ACK) |-> sda_oe)
      else $error("no ack on written byte");
endmodule : io_expander_core

// file: testbench/i2c_controller_model.sv
// Purpose: behavioural bus controller that drives the expander's bus pins
// Assumes: open-drain SDA with pull-up, the controller owns SCL
// Notes:   quarter sets the SCL pace; raise it to slow the bus
`timescale 1ns/1ns
module i2c_controller_model (
   // Clock
   input  wire logic clock,
   // Bus lines
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_low
);
   int quarter = 5;

   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask : tick

   // SDA only moves while SCL is low, so no false start or stop appears
   task automatic put_bit(input logic b, output logic seen);
      sda_low <= !b;
      tick(quarter);
      scl <= 1'b1;
      tick(quarter);
      seen = sda_line;
      tick(quarter);
      scl <= 1'b0;
      tick(quarter);
   endtask : put_bit

   task automatic start;
      sda_low <= 1'b0;
      scl <= 1'b1;
      tick(quarter);
      sda_low <= 1'b1;
      tick(quarter);
      scl <= 1'b0;
      tick(quarter);
   endtask : start

   task automatic stop;
      sda_low <= 1'b1;
      tick(quarter);
      scl <= 1'b1;
      tick(quarter);
      sda_low <= 1'b0;
      tick(quarter);
   endtask : stop

   // Ninth bit is released: target ack on writes, our nack on reads
   task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(d[i], s);
         r[i] = s;
      end
      put_bit(1'b1, s);
      ack = !s;
   endtask : xfer

   task automatic reg_write(input logic [6:0] a, input logic [2:0] cmd, input logic [7:0] d, output logic ok);
      logic [7:0] r;
      logic       k1, k2, k3;
      start();
      xfer({a, 1'b0}, r, k1);
      xfer({5'h00, cmd}, r, k2);
      xfer(d, r, k3);
      stop();
      ok = k1 && k2 && k3;
   endtask : reg_write

   task automatic reg_read(input logic [6:0] a, input logic [2:0] cmd, input logic ptr,
                           output logic [7:0] d, output logic ok);
      logic [7:0] r;
      logic       k1, k2, k3;
      k1 = 1'b1;
      k2 = 1'b1;
      if (ptr) begin
         start();
         xfer({a, 1'b0}, r, k1);
         xfer({5'h00, cmd}, r, k2);
         stop();
      end
      start();
      xfer({a, 1'b1}, r, k3);
      xfer(8'hFF, d, r[0]);
      stop();
      ok = k1 && k2 && k3;
   endtask : reg_read
endmodule : i2c_controller_model

// file: testbench/io_expander_core_test.sv
// Purpose: self-checking bench for the 16-bit expander core
// Assumes: pins and interrupt line have pull-ups
// Notes:   pin levels merge the core's drive with the bench's external level
`timescale 1ns/1ns
module io_expander_core_test;
   import expander_pkg::*;
   logic       clock = 1'b0;
   logic       rst_n = 1'b0;
   logic       addr_strap = 1'b0;
   logic [7:0] ext0 = 8'h00;
   logic [7:0] ext1 = 8'h00;
   logic       scl, sda_low, sda_oe, irq_oe;
   logic [7:0] p0_out, p1_out, p0_oe, p1_oe;
   int         error_cnt = 0;
   int         checks = 0;
   wire logic       sda_line = !sda_low && !sda_oe;
   wire logic [7:0] pin0 = (p0_oe & p0_out) | (~p0_oe & ext0);
   wire logic [7:0] pin1 = (p1_oe & p1_out) | (~p1_oe & ext1);
   wire logic [6:0] own = TARGET_BASE | {6'h00, addr_strap};

   always #10 clock = !clock;

   io_expander_core dut_u (.clock(clock), .rst_n(rst_n), .clock_enable(1'b1), .scl_in(scl),
      .sda_in(sda_line), .sda_oe(sda_oe), .addr_strap(addr_strap), .port0_pins_in(pin0),
      .port1_pins_in(pin1), .port0_pins_out(p0_out), .port1_pins_out(p1_out),
      .port0_pins_oe(p0_oe), .port1_pins_oe(p1_oe), .change_irq_oe(irq_oe));
   i2c_controller_model ctl_u (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [2:0] cmd, input logic [7:0] d);
      logic ok;
      ctl_u.reg_write(own, cmd, d, ok);
      check("write ack", ok, 1'b1);
   endtask : wr

   task automatic rd(input logic [2:0] cmd, input logic [7:0] exp, input logic ptr);
      logic [7:0] d;
      logic       ok;
      ctl_u.reg_read(own, cmd, ptr, d, ok);
      check("read ack", ok, 1'b1);
      check("read data", d, exp);
   endtask : rd

   // Bounded wait: a missing or stuck interrupt shows as a mismatch
   task automatic wait_irq(input logic v);
      int n = 0;
      while (irq_oe !== v && n < 8) begin
         @(posedge clock);
         n++;
      end
      check("irq", irq_oe, v);
   endtask : wait_irq

   task automatic t_reset;
      check("pin oe", {p1_oe, p0_oe}, 16'h0000);
      check("irq", irq_oe, 1'b0);
      for (int c = 2; c < 8; c++) begin
         rd(3'(c), c < 4 ? OUTPUT_RESET : c < 6 ? POLARITY_RESET : CONFIG_RESET, 1'b1);
      end
      rd(CMD_INPUT0, ext0, 1'b1);
      rd(CMD_INPUT1, ext1, 1'b1);
   endtask : t_reset

   task automatic t_ports;
      wr(CMD_CONFIG0, 8'h0F);
      wr(CMD_OUTPUT0, 8'hA5);
      check("pin oe", p0_oe, 8'hF0);
      check("pin out", p0_out & 8'hF0, 8'hA0);
      check("irq", irq_oe, 1'b0);
      wr(CMD_INPUT0, 8'h3C);
      rd(CMD_INPUT0, 8'hA0, 1'b1);
      wr(CMD_POLARITY1, 8'hF0);
      rd(CMD_INPUT1, 8'hF0, 1'b1);
      rd(CMD_INPUT1, 8'hF0, 1'b0);
      rd(CMD_OUTPUT0, 8'hA5, 1'b1);
      rd(CMD_CONFIG0, 8'h0F, 1'b1);
   endtask : t_ports

   task automatic t_irq;
      logic ok;
      ext1 <= 8'h01;
      wait_irq(1'b1);
      ext1 <= 8'h00;
      wait_irq(1'b0);
      ext1 <= 8'h80;
      wait_irq(1'b1);
      ctl_u.reg_write(own ^ 7'h01, CMD_INPUT1, 8'h00, ok);
      check("foreign ack", ok, 1'b0);
      check("irq", irq_oe, 1'b1);
      rd(CMD_INPUT1, 8'h70, 1'b1);
      check("irq", irq_oe, 1'b0);
      ext1 <= 8'h00;
      wait_irq(1'b1);
      rd(CMD_INPUT1, 8'hF0, 1'b0);
      check("irq", irq_oe, 1'b0);
      wr(CMD_OUTPUT0, 8'h05);
      check("irq", irq_oe, 1'b0);
      wr(CMD_CONFIG0, 8'hFF);
      check("irq", irq_oe, 1'b1);
      rd(CMD_INPUT0, 8'h00, 1'b1);
   endtask : t_irq

   task automatic t_strap;
      logic ok;
      addr_strap <= 1'b1;
      ctl_u.quarter = 12;
      @(posedge clock);
      ctl_u.reg_write(TARGET_BASE, CMD_OUTPUT1, 8'h00, ok);
      check("foreign ack", ok, 1'b0);
      rd(CMD_OUTPUT1, OUTPUT_RESET, 1'b1);
      ctl_u.quarter = 5;
   endtask : t_strap

   task automatic t_rst;
      wr(CMD_OUTPUT1, 8'h3C);
      wr(CMD_CONFIG1, 8'h00);
      check("pin out", {p1_oe, p1_out}, 16'hFF3C);
      rst_n <= 1'b0;
      repeat (6) @(posedge clock);
      check("pin oe", {p1_oe, p0_oe}, 16'h0000);
      check("pin out", p1_out, OUTPUT_RESET);
      rst_n <= 1'b1;
      repeat (10) @(posedge clock);
      rd(CMD_OUTPUT1, OUTPUT_RESET, 1'b1);
      rd(CMD_CONFIG1, CONFIG_RESET, 1'b1);
   endtask : t_rst

   task automatic close_out;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out

   initial begin
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      repeat (10) @(posedge clock);
      t_reset();
      t_ports();
      t_irq();
      t_strap();
      t_rst();
      close_out();
   end

   // Roughly four times the expected length of all transfers
   initial begin
      #1_800_000;
      error_cnt++;
      close_out();
   end
endmodule : io_expander_core_test
